// ### spi_nvm_pkg.sv
// Purpose: Shared constants, types and helpers of the serial memory block
// Assumes: One core clock at 100 MHz and a host-made serial clock
// Notes:   Figures here are used by the top, the port checks and the bench
package spi_nvm_pkg;

	localparam int unsigned REF_PERIOD_NS = 10;
	localparam int unsigned PROG_TIME_NS  = 5000000;
	localparam int unsigned PROG_CYCLES   = PROG_TIME_NS / REF_PERIOD_NS;

	localparam logic [7:0] OP_SET_LATCH = 8'h06;
	localparam logic [7:0] OP_CLR_LATCH = 8'h04;
	localparam logic [7:0] OP_STAT_RD   = 8'h05;
	localparam logic [7:0] OP_STAT_WR   = 8'h01;
	localparam logic [7:0] OP_ARRAY_RD  = 8'h03;
	localparam logic [7:0] OP_ARRAY_WR  = 8'h02;

	localparam int unsigned ST_PROTECT_PIN_ENABLE_BIT = 7;
	localparam int unsigned ST_BL_H = 3;
	localparam int unsigned ST_BL_L = 2;
	localparam int unsigned ST_WEL  = 1;
	localparam int unsigned ST_BUSY = 0;
	localparam logic [7:0]  ST_BUSY_VALUE = 8'hff;

	localparam logic [8:0] CNT_OPCODE   = 9'h008;
	localparam logic [8:0] CNT_STAT_WR  = 9'h010;
	localparam logic [8:0] CNT_ADDR_END = 9'h018;
	localparam logic [8:0] CNT_DATA_0   = 9'h020;
	localparam logic [8:0] CNT_PROG_END = 9'h118;
	localparam logic [8:0] CNT_TOP      = 9'h1ff;
	localparam logic [8:0] CNT_REWRAP   = 9'h120;
	localparam logic [4:0] PAGE_FIRST   = 5'h04;

	localparam int unsigned PAGE_BYTES  = 32;
	localparam logic [7:0]  ERASED_BYTE = 8'hff;

	typedef enum logic [2:0] {
		REQ_NONE  = 3'b000,
		REQ_SET   = 3'b001,
		REQ_CLR   = 3'b010,
		REQ_STATW = 3'b011,
		REQ_PROG  = 3'b100
	} req_kind_t;

	typedef struct packed {
		logic      latch;
		logic      protect_pin_enable_bit;
		logic [1:0] lock;
		logic      busy;
		req_kind_t busy_kind;
		logic [7:0] stage;
		logic      abort;
		logic      cs_n_q;
		logic      guard_n_q;
	} core_state_t;

	// True when the top bits of an address fall in a locked segment
	function automatic logic is_locked(input logic [1:0] lock, input logic [1:0] top);
		unique case (lock)
			2'b00:   is_locked = 1'b0;
			2'b01:   is_locked = (top == 2'b11);
			2'b10:   is_locked = top[1];
			default: is_locked = 1'b1;
		endcase
	endfunction

endpackage

// ### sync2.sv
// Purpose: Two-stage synchroniser for levels entering a clock domain
// Assumes: Each bit is a slow level, stable across several destination edges
// Notes:   The first stage feeds the second stage only
`timescale 1ns/10ps
`default_nettype none
module sync2 #(
	parameter int unsigned  W       = 1,
	parameter logic [W-1:0] RST_VAL = '0
) (
	input  wire logic         clk_i,   // Destination clock
	input  wire logic         rst_n_i, // Async reset, active low
	input  wire logic [W-1:0] d_i,     // Asynchronous level
	output logic      [W-1:0] q_o      // Synchronised level
);
	logic [W-1:0] meta_r;

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			meta_r <= RST_VAL;
			q_o    <= RST_VAL;
		end else begin
			meta_r <= d_i;
			q_o    <= meta_r;
		end
	end
endmodule
`default_nettype wire

// ### prog_timer.sv
// Purpose: Self-timed programming cycle counter
// Assumes: start_i is a one-cycle pulse, ignored while busy
// Notes:   done_o pulses once in the last cycle of busy
`timescale 1ns/10ps
`default_nettype none
module prog_timer #(
	parameter int unsigned CYCLES = 500000
) (
	input  wire logic ref_clk_i, // Core clock
	input  wire logic nrst_i,    // Async reset, active low
	input  wire logic start_i,   // Begin a cycle
	output logic      busy_o,    // Cycle running
	output logic      done_o     // Cycle ends now
);
	localparam int unsigned CW = $clog2(CYCLES + 1);

	typedef struct packed {
		logic          busy;
		logic [CW-1:0] cnt;
	} timer_state_t;

	timer_state_t s_r;
	timer_state_t s_nxt;

	always_comb begin
		s_nxt = s_r;
		if (!s_r.busy && start_i) begin
			s_nxt.busy = 1'b1;
			s_nxt.cnt  = CW'(CYCLES - 1);
		end else if (s_r.busy) begin
			if (s_r.cnt == '0) begin
				s_nxt.busy = 1'b0;
			end else begin
				s_nxt.cnt = s_r.cnt - 1'b1;
			end
		end
	end

	always_ff @(posedge ref_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign busy_o = s_r.busy;
	assign done_o = s_r.busy && (s_r.cnt == '0);
endmodule
`default_nettype wire

// ### spi_nvm_dev.sv
// Purpose: Device side of a byte-wide serial memory with write protection
// Assumes: Host keeps pause changes to serial clock low phases
// Notes:   Serial logic on the link clock, cycle control on ref_clk_i
//
// Summary of operation
// - Chip select high: output off, standby unless a cycle runs.
// - Read data changes after each falling serial clock edge.
// - Opcodes, address and data captured on rising serial clock edges.
// - After power-up nothing happens until chip select falls once.
// - Guard pin low with enable bit set refuses status writes.
// - Guard pin falling while selected aborts a pending status write.
// - Enable bit clear makes the guard pin ignored.
// - Pause low freezes the sequence without resetting it.
// - An eight-bit instruction register loads serially on rising edges.
// - All bytes travel most significant bit first.
// - First bit sampled on first rising edge after select falls.
// - Serial logic is static; the clock may stop anywhere.
// - After pause, operation resumes at the same bit.
// - Programming completes only with the latch set; commands set or clear it.
// - Latch clears at power-up and after any programming cycle.
// - Status read works at any time, including mid-cycle.
// - Status: enable, spare, lock range, latch, busy; three bits writable.
// - Latch and busy flags are read-only and show internal state.
// - Busy reads 1 in a cycle, all other bits then read 1.
// - Lock range protects none, top fourth, top half or all.
// - Set, clear latch and status read opcodes are 06, 04, 05.
// - Status write 01, array read 03, sector program 02.
// - Array read: opcode, 16-bit address, streaming bytes with wrapping address.
// - Set-latch needs select raised after eight bits, else ignored.
`timescale 1ns/10ps
`default_nettype none
module spi_nvm_dev
	import spi_nvm_pkg::*;
#(
	parameter int unsigned ADDR_W      = 13,
	parameter int unsigned PROG_CYC    = PROG_CYCLES
) (
	input  wire logic ref_clk_i,            // Core clock, 100 MHz
	input  wire logic nrst_i,               // Async reset, active low
	input  wire logic sclk_i,               // Serial clock from host
	input  wire logic cs_n_i,               // Chip select, active low
	input  wire logic si_i,                 // Serial data in
	input  wire logic pause_n_i,            // Pause, active low
	input  wire logic write_guard_pin_n_i,  // Status write guard, active low
	output logic      so_o,                 // Serial data out
	output logic      so_oe_o,              // Serial out enable
	output logic      standby_o             // Idle power state
);
	localparam int unsigned DEPTH  = 1 << ADDR_W;
	localparam int unsigned SECT_W = ADDR_W - 5;

	typedef struct packed {
		logic [8:0]  cnt;
		logic [7:0]  shift;
		logic [7:0]  opcode;
		logic [15:0] addr;
		logic [7:0]  tx;
		logic        tx_on;
	} link_state_t;

	logic [7:0]        mem_r [DEPTH];
	logic [7:0]        page_r [PAGE_BYTES];
	logic [SECT_W-1:0] sect_r;
	logic [7:0]        statw_r;
	req_kind_t         req_r;
	logic              armed_r;
	link_state_t       l_r;
	link_state_t       l_nxt;
	logic              so_r;
	logic              so_en_r;
	logic              link_rst_n;
	logic [7:0]        status;
	logic [7:0]        status_l;
	logic [2:0]        req_c;
	logic [1:0]        pins_c;
	core_state_t       c_r;
	core_state_t       c_nxt;
	logic              t_start;
	logic              t_busy;
	logic              t_done;

	// Select high holds the frame logic in reset
	assign link_rst_n = nrst_i & ~cs_n_i;

	// Unlocked by the first select fall after reset
	always_ff @(negedge cs_n_i or negedge nrst_i) begin
		if (!nrst_i) begin
			armed_r <= 1'b0;
		end else begin
			armed_r <= 1'b1;
		end
	end

	sync2 #(.W(8)) u_stat_sync (
		.clk_i   (sclk_i),
		.rst_n_i (nrst_i),
		.d_i     (status),
		.q_o     (status_l)
	);

	// Frame state: counter, shifter, opcode, address, transmit byte
	always_comb begin
		logic [7:0] op_now;
		logic [8:0] n;
		op_now = 8'h00;
		n      = '0;
		l_nxt  = l_r;
		l_nxt.shift = {l_r.shift[6:0], si_i};
		n = (l_r.cnt == CNT_TOP) ? CNT_REWRAP : l_r.cnt + 9'h001;
		l_nxt.cnt = n;
		if (n == CNT_OPCODE) begin
			l_nxt.opcode = l_nxt.shift;
		end
		op_now = (n == CNT_OPCODE) ? l_nxt.shift : l_r.opcode;
		if (n > CNT_OPCODE && n <= CNT_ADDR_END) begin
			l_nxt.addr = {l_r.addr[14:0], si_i};
		end
		if (n[2:0] == 3'h0 && n >= CNT_OPCODE && op_now == OP_STAT_RD) begin
			l_nxt.tx    = status_l;
			l_nxt.tx_on = 1'b1;
		end
		if (n[2:0] == 3'h0 && n >= CNT_ADDR_END && op_now == OP_ARRAY_RD) begin
			l_nxt.tx    = mem_r[l_nxt.addr[ADDR_W-1:0]];
			l_nxt.addr  = l_nxt.addr + 16'h0001;
			l_nxt.tx_on = 1'b1;
		end
	end

	// Rising edges advance only when unlocked and not paused
	always_ff @(posedge sclk_i or negedge link_rst_n) begin
		if (!link_rst_n) begin
			l_r <= '0;
		end else if (armed_r && pause_n_i) begin
			l_r <= l_nxt;
		end
	end

	// Request, staged data and page survive the select rise for the core
	always_ff @(posedge sclk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			req_r   <= REQ_NONE;
			statw_r <= 8'h00;
			sect_r  <= '0;
			for (int i = 0; i < PAGE_BYTES; i++) begin
				page_r[i] <= ERASED_BYTE;
			end
		end else if (armed_r && pause_n_i && !cs_n_i) begin
			req_r <= REQ_NONE;
			if (l_nxt.cnt == CNT_OPCODE && l_nxt.opcode == OP_SET_LATCH) begin
				req_r <= REQ_SET;
			end
			if (l_nxt.cnt == CNT_OPCODE && l_nxt.opcode == OP_CLR_LATCH) begin
				req_r <= REQ_CLR;
			end
			if (l_nxt.cnt == CNT_STAT_WR && l_r.opcode == OP_STAT_WR) begin
				req_r   <= REQ_STATW;
				statw_r <= l_nxt.shift;
			end
			if (l_nxt.cnt == CNT_PROG_END && l_r.opcode == OP_ARRAY_WR) begin
				req_r <= REQ_PROG;
			end
			// Page frozen while a cycle may still be copying it
			if (l_r.opcode == OP_ARRAY_WR && !status_l[ST_BUSY]
				&& l_nxt.cnt[2:0] == 3'h0
				&& l_nxt.cnt >= CNT_DATA_0 && l_nxt.cnt <= CNT_PROG_END) begin
				page_r[5'(l_r.addr[4:0] + l_nxt.cnt[7:3] - PAGE_FIRST)] <= l_nxt.shift;
				sect_r <= l_r.addr[ADDR_W-1:5];
			end
		end
	end

	// Output bit chosen on the falling edge, msb first
	always_ff @(negedge sclk_i or negedge link_rst_n) begin
		if (!link_rst_n) begin
			so_r    <= 1'b0;
			so_en_r <= 1'b0;
		end else if (pause_n_i) begin
			so_r    <= l_r.tx[3'h7 - l_r.cnt[2:0]];
			so_en_r <= l_r.tx_on;
		end
	end

	assign so_o    = so_r;
	assign so_oe_o = so_en_r & ~cs_n_i & pause_n_i;

	// Core domain
	sync2 #(.W(3)) u_req_sync (
		.clk_i   (ref_clk_i),
		.rst_n_i (nrst_i),
		.d_i     (req_r),
		.q_o     (req_c)
	);

	// Resets to the idle pin levels, so no false edge follows reset
	sync2 #(.W(2), .RST_VAL(2'b11)) u_pin_sync (
		.clk_i   (ref_clk_i),
		.rst_n_i (nrst_i),
		.d_i     ({cs_n_i, write_guard_pin_n_i}),
		.q_o     (pins_c)
	);

	prog_timer #(.CYCLES(PROG_CYC)) u_timer (
		.ref_clk_i (ref_clk_i),
		.nrst_i    (nrst_i),
		.start_i   (t_start),
		.busy_o    (t_busy),
		.done_o    (t_done)
	);

	// Status view; a running cycle reads as all ones
	always_comb begin
		status = 8'h00;
		status[ST_PROTECT_PIN_ENABLE_BIT]           = c_r.protect_pin_enable_bit;
		status[ST_BL_H:ST_BL_L]   = c_r.lock;
		status[ST_WEL]            = c_r.latch;
		status[ST_BUSY]           = c_r.busy;
		if (c_r.busy) begin
			status = ST_BUSY_VALUE;
		end
	end

	always_comb begin
		logic protect;
		logic cs_rise;
		logic lock_hit;
		protect  = c_r.protect_pin_enable_bit & ~pins_c[0];
		cs_rise  = pins_c[1] & ~c_r.cs_n_q;
		lock_hit = is_locked(c_r.lock, sect_r[SECT_W-1:SECT_W-2]);
		c_nxt    = c_r;
		t_start  = 1'b0;
		c_nxt.cs_n_q    = pins_c[1];
		c_nxt.guard_n_q = pins_c[0];
		// Set after clear: a guard fall at the select fall still aborts
		if (!pins_c[1] && c_r.cs_n_q) begin
			c_nxt.abort = 1'b0;
		end
		if (!pins_c[1] && c_r.guard_n_q && !pins_c[0] && c_r.protect_pin_enable_bit) begin
			c_nxt.abort = 1'b1;
		end
		if (cs_rise && !c_r.busy) begin
			unique case (req_c)
				REQ_SET: c_nxt.latch = 1'b1;
				REQ_CLR: c_nxt.latch = 1'b0;
				REQ_STATW: begin
					if (c_r.latch && !protect && !c_nxt.abort) begin
						t_start         = 1'b1;
						c_nxt.busy      = 1'b1;
						c_nxt.busy_kind = REQ_STATW;
						c_nxt.stage     = statw_r;
					end
				end
				REQ_PROG: begin
					if (c_r.latch && !lock_hit) begin
						t_start         = 1'b1;
						c_nxt.busy      = 1'b1;
						c_nxt.busy_kind = REQ_PROG;
					end
				end
				default: ;
			endcase
		end
		if (t_done) begin
			c_nxt.busy  = 1'b0;
			c_nxt.latch = 1'b0;
			if (c_r.busy_kind == REQ_STATW) begin
				c_nxt.protect_pin_enable_bit = c_r.stage[ST_PROTECT_PIN_ENABLE_BIT];
				c_nxt.lock = c_r.stage[ST_BL_H:ST_BL_L];
			end
		end
	end

	always_ff @(posedge ref_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			c_r <= '{busy_kind: REQ_NONE, cs_n_q: 1'b1, guard_n_q: 1'b1, default: '0};
		end else begin
			c_r <= c_nxt;
		end
	end

	// Sector copy happens once, at the end of the cycle
	always_ff @(posedge ref_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			for (int i = 0; i < DEPTH; i++) begin
				mem_r[i] <= ERASED_BYTE;
			end
		end else if (t_done && c_r.busy_kind == REQ_PROG) begin
			for (int i = 0; i < PAGE_BYTES; i++) begin
				mem_r[{sect_r, 5'(i)}] <= page_r[i];
			end
		end
	end

	assign standby_o = pins_c[1] & ~t_busy;
endmodule
`default_nettype wire

// ### spi_nvm_chk.sv
// Purpose: Port checks of the serial memory device
// Assumes: Host keeps the serial clock low outside frames
// Notes:   Bound to the device top from the bench
`timescale 1ns/10ps
`default_nettype none
module spi_nvm_chk
	import spi_nvm_pkg::*;
(
	input wire logic ref_clk_i, // Core clock
	input wire logic nrst_i,    // Reset, active low
	input wire logic sclk_i,    // Serial clock
	input wire logic cs_n_i,    // Select, active low
	input wire logic si_i,      // Serial in
	input wire logic pause_n_i, // Pause, active low
	input wire logic so_o,      // Serial out
	input wire logic so_oe_o,   // Out enable
	input wire logic standby_o  // Standby
);
	logic [8:0] rise_r;
	logic [7:0] op_r;
	logic       so_rise_r;
	logic       armed_r;
	// Bits before the first select fall are ignored, as in the device
	always_ff @(negedge cs_n_i or negedge nrst_i) begin
		if (!nrst_i)
			armed_r <= 1'b0;
		else
			armed_r <= 1'b1;
	end
	// Cleared by select high, as the frame logic is
	always_ff @(posedge sclk_i or posedge cs_n_i or negedge nrst_i) begin
		if (!nrst_i || cs_n_i) begin
			rise_r <= 9'h000;
			op_r <= 8'h00;
			so_rise_r <= 1'b0;
		end else begin
			so_rise_r <= so_o;
			if (armed_r && pause_n_i && rise_r != 9'h1ff)
				rise_r <= rise_r + 9'h001;
			if (armed_r && pause_n_i && rise_r < 9'h008)
				op_r <= {op_r[6:0], si_i};
		end
	end
	chk_oe_deselect: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
		cs_n_i |-> !so_oe_o) else $error("output driven while deselected");
	chk_standby_active: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
		!cs_n_i [*5] |-> !standby_o) else $error("standby while selected");
	chk_oe_pause: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
		!pause_n_i |-> !so_oe_o) else $error("output driven in pause");
	chk_so_fall_only: assert property (@(negedge sclk_i) disable iff (!nrst_i || cs_n_i)
		so_oe_o |-> so_o == so_rise_r) else $error("output moved in high phase");
	chk_so_pause_hold: assert property (@(negedge sclk_i) disable iff (!nrst_i || cs_n_i)
		!pause_n_i |=> $stable(so_o)) else $error("output moved in pause");
	chk_oe_after_op: assert property (@(posedge sclk_i) disable iff (!nrst_i || cs_n_i)
		so_oe_o |-> rise_r >= 9'h008) else $error("output before opcode end");
	chk_status_answer: assert property (@(posedge sclk_i) disable iff (!nrst_i || cs_n_i)
		rise_r == 9'h008 && op_r == OP_STAT_RD && pause_n_i |-> so_oe_o)
		else $error("no status answer");
	chk_array_answer: assert property (@(posedge sclk_i) disable iff (!nrst_i || cs_n_i)
		rise_r == 9'h018 && op_r == OP_ARRAY_RD && pause_n_i |-> so_oe_o)
		else $error("no array answer");
	chk_quiet_opcode: assert property (@(posedge sclk_i) disable iff (!nrst_i || cs_n_i)
		rise_r >= 9'h008 && op_r != OP_STAT_RD && op_r != OP_ARRAY_RD |-> !so_oe_o)
		else $error("output on silent opcode");
	cov_status: cover property (@(posedge sclk_i) rise_r == 9'h008 && op_r == OP_STAT_RD);
	cov_array: cover property (@(posedge sclk_i) rise_r == 9'h018 && op_r == OP_ARRAY_RD);
	cov_pause: cover property (@(negedge sclk_i) !cs_n_i && !pause_n_i);
endmodule
`default_nettype wire

// ### spi_host_model.sv
// Purpose: Host controller driving the serial memory link
// Assumes: Mode with clock idle low, 15 ns serial period
// Notes:   Pauses with the clock still toggling, as on a shared bus
`timescale 1ns/10ps
`default_nettype none
module spi_host_model (
	output logic      sclk_o,    // Serial clock
	output logic      cs_n_o,    // Select, active low
	output logic      si_o,      // Serial data to device
	output logic      pause_n_o, // Pause, active low
	output logic      guard_n_o, // Guard pin
	input  wire logic so_i,      // Serial data from device
	input  wire logic so_oe_i    // Device drives so_i
);
	logic [7:0] rx;
	int         pause_at = -1;
	event       got;
	initial begin
		sclk_o = 1'b0;
		cs_n_o = 1'b1;
		si_o = 1'b0;
		pause_n_o = 1'b1;
		guard_n_o = 1'b1;
	end
	task automatic start();
		cs_n_o = 1'b0;
		#20;
	endtask
	task automatic stop();
		#10;
		cs_n_o = 1'b1;
		// Released line must not keep the last bit
		si_o = ~si_o;
		#80;
	endtask
	task automatic xbyte(input logic [7:0] tx, input bit rd);
		for (int i = 7; i >= 0; i--) begin
			if (i == pause_at) begin
				#3 pause_n_o = 1'b0;
				repeat (3) begin
					#7.5 sclk_o = 1'b1;
					#7.5 sclk_o = 1'b0;
				end
				#3 pause_n_o = 1'b1;
			end
			si_o = tx[i];
			#7.5 sclk_o = 1'b1;
			rx[i] = so_oe_i ? so_i : 1'bx;
			#7.5 sclk_o = 1'b0;
		end
		if (rd)
			->got;
	endtask
endmodule
`default_nettype wire

// ### tb.sv
// Purpose: Self-checking bench of the serial memory device
// Assumes: Short program cycle of 50 core cycles
// Notes:   Expected bytes queue up; a watcher compares host reads
`timescale 1ns/10ps
`default_nettype none
module tb;
	import spi_nvm_pkg::*;
	logic        ref_clk = 1'b0;
	logic        nrst = 1'b0;
	logic        sclk, cs_n, si, pause_n, guard_n, so, so_oe, standby;
	int          miscompares = 0;
	int          checked = 0;
	int          seed = 76828;
	logic [15:0] exp_q[$];
	logic [7:0]  dat[32];
	always #5 ref_clk = ~ref_clk;
	spi_nvm_dev #(.ADDR_W(13), .PROG_CYC(50)) DUT (.ref_clk_i(ref_clk), .nrst_i(nrst),
		.sclk_i(sclk), .cs_n_i(cs_n), .si_i(si), .pause_n_i(pause_n),
		.write_guard_pin_n_i(guard_n), .so_o(so), .so_oe_o(so_oe), .standby_o(standby));
	spi_host_model h (.sclk_o(sclk), .cs_n_o(cs_n), .si_o(si), .pause_n_o(pause_n),
		.guard_n_o(guard_n), .so_i(so), .so_oe_i(so_oe));
	task automatic end_of_test();
		$display("checked %0d miscompares %0d", checked, miscompares);
		if (miscompares == 0 && checked > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	always @(h.got) begin
		logic [15:0] n;
		n = exp_q.pop_front();
		checked++;
		if ((h.rx & n[15:8]) !== n[7:0]) begin
			miscompares++;
			$display("mismatch at %0t got %h exp %h", $time, h.rx, n[7:0]);
		end
	end
	task automatic cmd(input logic [7:0] op);
		h.start();
		h.xbyte(op, 1'b0);
		h.stop();
	endtask
	task automatic st_rd(input logic [7:0] e, input logic [7:0] m);
		exp_q.push_back({m, e & m});
		h.start();
		h.xbyte(OP_STAT_RD, 1'b0);
		h.xbyte(8'h00, 1'b1);
		h.stop();
	endtask
	task automatic st_wr(input logic [7:0] v);
		cmd(OP_SET_LATCH);
		h.start();
		h.xbyte(OP_STAT_WR, 1'b0);
		h.xbyte(v, 1'b0);
		h.stop();
	endtask
	task automatic prog(input logic [15:0] a);
		cmd(OP_SET_LATCH);
		h.start();
		h.xbyte(OP_ARRAY_WR, 1'b0);
		h.xbyte(a[15:8], 1'b0);
		h.xbyte(a[7:0], 1'b0);
		for (int i = 0; i < 32; i++)
			h.xbyte(dat[i], 1'b0);
		h.stop();
	endtask
	task automatic rd_byte(input logic [7:0] e);
		exp_q.push_back({8'hff, e});
		h.xbyte(8'h00, 1'b1);
	endtask
	task automatic rd_open(input logic [15:0] a);
		h.start();
		h.xbyte(OP_ARRAY_RD, 1'b0);
		h.xbyte(a[15:8], 1'b0);
		h.xbyte(a[7:0], 1'b0);
	endtask
	initial begin
		// Tests need about 120 us; generous margin
		#300000;
		miscompares++;
		end_of_test();
	end
	initial begin
		bit lkd;
		@(negedge ref_clk);
		h.cs_n_o = 1'b0;
		@(negedge ref_clk);
		nrst = 1'b1;
		repeat (4) @(negedge ref_clk);
		// Select low since reset, no fall yet: the output must stay undriven
		exp_q.push_back({8'hff, 8'hxx});
		h.xbyte(OP_STAT_RD, 1'b0);
		h.xbyte(8'h00, 1'b1);
		h.stop();
		st_rd(8'h00, 8'hff);
		cmd(OP_SET_LATCH);
		st_rd(8'h02, 8'hff);
		cmd(OP_CLR_LATCH);
		st_rd(8'h00, 8'hff);
		h.start();
		h.xbyte(OP_SET_LATCH, 1'b0);
		h.xbyte(8'h00, 1'b0);
		h.stop();
		st_rd(8'h00, 8'hff);
		foreach (dat[i]) dat[i] = 8'($random(seed));
		prog(16'h0000);
		st_rd(8'hff, 8'hff);
		#1000;
		st_rd(8'h00, 8'hff);
		h.pause_at = 3;
		rd_open(16'h0000);
		for (int i = 0; i < 33; i++)
			rd_byte(i < 32 ? dat[i] : 8'hff);
		h.stop();
		h.pause_at = -1;
		rd_open(16'h1fff);
		rd_byte(8'hff);
		rd_byte(dat[0]);
		h.stop();
		// Each lock code against every segment
		for (int k = 0; k < 4; k++) begin
			st_wr({4'h0, k[1:0], 2'b00});
			#1000;
			st_rd({4'h0, k[1:0], 2'b00}, 8'hff);
			for (int s = 0; s < 4; s++) begin
				lkd = (k == 3) || (k == 2 && s > 1) || (k == 1 && s == 3);
				prog({3'b000, s[1:0], 11'h000});
				st_rd(lkd ? {4'h0, k[1:0], 2'b10} : 8'hff, 8'hff);
				#1000;
			end
		end
		st_wr(8'h80);
		#1000;
		h.guard_n_o = 1'b0;
		st_wr(8'h8c);
		st_rd(8'h80, 8'hfd);
		h.guard_n_o = 1'b1;
		cmd(OP_SET_LATCH);
		h.start();
		h.xbyte(OP_STAT_WR, 1'b0);
		h.guard_n_o = 1'b0;
		h.xbyte(8'h8c, 1'b0);
		// Pin high again before select rises, so only the abort refuses
		h.guard_n_o = 1'b1;
		#20;
		h.stop();
		st_rd(8'h80, 8'hfd);
		st_wr(8'h00);
		#1000;
		h.guard_n_o = 1'b0;
		st_wr(8'h0c);
		st_rd(8'hff, 8'hff);
		#1000;
		st_rd(8'h0c, 8'hff);
		end_of_test();
	end
endmodule
bind spi_nvm_dev spi_nvm_chk chk (.ref_clk_i(ref_clk_i), .nrst_i(nrst_i), .sclk_i(sclk_i),
	.cs_n_i(cs_n_i), .si_i(si_i), .pause_n_i(pause_n_i), .so_o(so_o), .so_oe_o(so_oe_o),
	.standby_o(standby_o));
`default_nettype wire
